/* File: hw/cit_pkg.sv */
// Shared constants, register layouts and types of the interval timer.
package cit_pkg;
    localparam int          CLK_NS        = 10;
    localparam int          MS_NS         = 1000000;
    localparam int          MS_CYC        = MS_NS / CLK_NS;
    localparam int          MS_PER_S      = 1000;
    localparam int          T_TIMER_RST_MS = 3000;
    localparam int          T_TOTAL_RST_MS = 10000;
    localparam int          T_EXT_SLOW_MS = 1000;
    localparam int          T_EXT_FAST_MS = 2;
    localparam int          S_PER_HR      = 3600;
    localparam logic [3:0]  FLAG_S        = 4'h1;
    localparam logic [3:0]  FLAG_PERIOD_S = 4'h5;
    localparam logic [7:0]  A_CTRL        = 8'h00;
    localparam logic [7:0]  A_SETPOINT    = 8'h04;
    localparam logic [7:0]  A_CYCLES      = 8'h08;
    localparam logic [7:0]  A_GAP         = 8'h0C;
    localparam logic [7:0]  A_OUT0        = 8'h10;
    localparam logic [7:0]  A_OUT1        = 8'h14;
    localparam logic [7:0]  A_OUT2        = 8'h18;
    localparam logic [7:0]  A_TOTAL_CLR   = 8'h1C;
    localparam logic [7:0]  A_ELAPSED     = 8'h20;
    localparam logic [7:0]  A_TOTAL       = 8'h24;
    localparam logic [7:0]  A_STATE       = 8'h28;
    localparam logic [7:0]  A_READOUT     = 8'h2C;
    localparam logic [31:0] CLEAR_KEY     = 32'h0000_5A5A;
    localparam logic [31:0] CTRL_RST      = 32'h0000_044C;
    localparam logic [2:0]  SRC_LOCAL     = 3'h4;
    localparam logic [1:0]  PF_IDLE       = 2'h0;
    localparam logic [1:0]  PF_PAUSE      = 2'h1;
    localparam logic [1:0]  RD_OFF        = 2'h0;
    localparam logic [1:0]  RD_PERIODIC   = 2'h2;

    typedef enum logic [4:0] {
        ST_RESET = 5'h01,
        ST_RUN   = 5'h02,
        ST_DELAY = 5'h04,
        ST_PAUSE = 5'h08,
        ST_DONE  = 5'h10
    } cit_state_t;

    typedef struct packed {
        logic [17:0] rsvd;
        logic [1:0]  units;
        logic [1:0]  readout;
        logic        repeat_en;
        logic        ext_fast;
        logic        total_rst_en;
        logic        timer_rst_en;
        logic [1:0]  pf_policy;
        logic        count_down;
        logic [2:0]  source;
    } cit_ctrl_t;

    typedef struct packed {
        logic [7:0]  rsvd;
        logic [15:0] delay;
        logic [2:0]  off_st;
        logic [2:0]  on_st;
        logic        invert;
        logic        enable;
    } cit_out_cfg_t;

    typedef struct packed {
        logic        active;
        logic        pending;
        logic [15:0] cnt;
    } cit_out_run_t;
endpackage

/* File: hw/cit_timer.sv */
// Interval timer core with register port, state machine and outputs.
// Summary of operation
// - Five start/stop sources: A/b high, A/b low, A high/low, A low/high, buttons.
// - Direction bit picks counting up to setpoint or down to zero.
// - Start events are ignored while the setpoint is zero.
// - Idle policy: after power returns, sit complete holding the value.
// - Pause policy: after power returns, sit paused if running or in the gap; a start resumes.
// - Continue policy: timing carries on by itself after power returns.
// - Timer-reset combo held over three seconds reloads the timer.
// - Total-reset combo held over ten seconds clears the run total.
// - External contact resets only after closure of 1 s or 2 ms.
// - Status output turns on entering a chosen state; polarity reversible.
// - Status output turns off entering a second chosen state.
// - Status output activates after a configurable on-delay.
// - Status enable gates the output and keeps its settings.
// - Control output 1 turns on at a chosen state, invertible, enabled.
// - Control output 1 turns off at a second chosen state.
// - Control output 1 closes after an on-delay in seconds.
// - Control output 2 behaves as an independent copy of output 1.
// - Repeat feature runs the period a set number of times, switchable.
// - A restart gap separates successive repeated periods.
// - Elapsed time formats h:m:s, h:m, m:s or s; total in hours.
// - Lower readout shows setpoint, or cycles, gap countdown and phase flag.
// - Writing the confirmation key clears the run total for good.
// - Reset state stops the timer loaded with zero or the setpoint.
// - Stop pauses running or gap; start returns to the paused-from state.
`timescale 1ns/100ps
module cit_timer
    import cit_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYC
)
(
    // Clock and reset.
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    // Register port.
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wr_data_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rd_data_o,
    // Conditioned sensor inputs, buttons and contacts.
    input  wire logic        in_a_i,
    input  wire logic        in_b_i,
    input  wire logic        btn_start_i,
    input  wire logic        btn_stop_i,
    input  wire logic        btn_timer_rst_i,
    input  wire logic        btn_total_rst_i,
    input  wire logic        display_mode_i,
    input  wire logic        ext_reset_i,
    input  wire logic        power_fail_i,
    // Outputs.
    output logic             status_o,
    output logic      [1:0]  relay_o,
    output logic      [4:0]  timer_state_o,
    output logic      [31:0] lower_readout_o,
    output logic             phase_flag_o
);

    typedef struct packed {
        cit_ctrl_t               ctrl;
        logic [23:0]             setpoint;
        logic [6:0]              cyc_req;
        logic [15:0]             gap;
        cit_out_cfg_t [2:0]      ocfg;
        cit_out_run_t [2:0]      orun;
        cit_state_t              st;
        cit_state_t              prev;
        logic [23:0]             value;
        logic [6:0]              cyc_done;
        logic [15:0]             gap_left;
        logic [11:0]             tot_sec;
        logic [19:0]             tot_hr;
        logic [16:0]             ms_cnt;
        logic [9:0]              ms_of_s;
        logic                    a_q;
        logic                    b_q;
        logic                    pf_q;
        logic [13:0]             hold_t;
        logic [13:0]             hold_g;
        logic [9:0]              ext_ms;
        logic [3:0]              flag_cnt;
        logic [3:0]              per_cnt;
        logic [2:0]              outs;
        logic [31:0]             lower;
        logic                    flag;
        logic [31:0]             rdata;
    } cit_regs_t;

    cit_regs_t  q;
    cit_regs_t  n;
    logic       ms_tick;
    logic       sec;
    logic       start_ev;
    logic       stop_ev;
    logic       rst_ev;
    logic       ended;
    logic [23:0] load_val;
    logic [9:0] ext_lim;

    function automatic cit_state_t st_of(input logic [2:0] idx);
        case (idx)
            3'h0:    st_of = ST_RESET;
            3'h1:    st_of = ST_RUN;
            3'h2:    st_of = ST_DELAY;
            3'h3:    st_of = ST_PAUSE;
            default: st_of = ST_DONE;
        endcase
    endfunction

    function automatic logic [23:0] fmt_time(input logic [23:0] v,
                                             input logic [1:0]  u);
        logic [23:0] h;
        logic [23:0] m;
        logic [23:0] s;
        logic [23:0] tm;
        h  = v / 24'(S_PER_HR);
        tm = v / 24'h00003C;
        m  = tm % 24'h00003C;
        s  = v % 24'h00003C;
        case (u)
            2'h0:    fmt_time = {h[7:0], m[7:0], s[7:0]};
            2'h1:    fmt_time = {h[7:0], m[7:0], 8'h00};
            2'h2:    fmt_time = {8'h00, tm[7:0], s[7:0]};
            default: fmt_time = v;
        endcase
    endfunction

    always_comb
    begin
        n         = q;
        n.rdata   = 32'h0000_0000;
        ms_tick   = (q.ms_cnt == 17'(MS_CYCLES - 1));
        n.ms_cnt  = ms_tick ? 17'h00000 : q.ms_cnt + 17'h00001;
        sec       = 1'b0;
        if (ms_tick)
        begin
            sec       = (q.ms_of_s == 10'(MS_PER_S - 1));
            n.ms_of_s = sec ? 10'h000 : q.ms_of_s + 10'h001;
        end
        sec       = sec & ~power_fail_i;
        n.a_q     = in_a_i;
        n.b_q     = in_b_i;
        n.pf_q    = power_fail_i;
        load_val  = q.ctrl.count_down ? q.setpoint : 24'h000000;
        // Start and stop event decode.
        case (q.ctrl.source)
            3'h0:
            begin
                start_ev = in_a_i & ~q.a_q;
                stop_ev  = in_b_i & ~q.b_q;
            end
            3'h1:
            begin
                start_ev = ~in_a_i & q.a_q;
                stop_ev  = ~in_b_i & q.b_q;
            end
            3'h2:
            begin
                start_ev = in_a_i & ~q.a_q;
                stop_ev  = ~in_a_i & q.a_q;
            end
            3'h3:
            begin
                start_ev = ~in_a_i & q.a_q;
                stop_ev  = in_a_i & ~q.a_q;
            end
            default:
            begin
                start_ev = btn_start_i;
                stop_ev  = btn_stop_i;
            end
        endcase
        start_ev = start_ev & (q.setpoint != 24'h000000) & ~power_fail_i;
        stop_ev  = stop_ev & ~power_fail_i;
        // Front-panel hold timers fire once per hold.
        rst_ev = 1'b0;
        if (display_mode_i & btn_timer_rst_i & q.ctrl.timer_rst_en)
        begin
            if (ms_tick & (q.hold_t <= 14'(T_TIMER_RST_MS)))
            begin
                n.hold_t = q.hold_t + 14'h0001;
                rst_ev   = (q.hold_t == 14'(T_TIMER_RST_MS));
            end
        end
        else
        begin
            n.hold_t = 14'h0000;
        end
        if (display_mode_i & btn_total_rst_i & q.ctrl.total_rst_en)
        begin
            if (ms_tick & (q.hold_g <= 14'(T_TOTAL_RST_MS)))
            begin
                n.hold_g = q.hold_g + 14'h0001;
                if (q.hold_g == 14'(T_TOTAL_RST_MS))
                begin
                    n.tot_sec = 12'h000;
                    n.tot_hr  = 20'h00000;
                end
            end
        end
        else
        begin
            n.hold_g = 14'h0000;
        end
        // External contact qualification.
        ext_lim = q.ctrl.ext_fast ? 10'(T_EXT_FAST_MS) : 10'(T_EXT_SLOW_MS);
        if (ext_reset_i)
        begin
            if (ms_tick & (q.ext_ms < ext_lim))
            begin
                n.ext_ms = q.ext_ms + 10'h001;
                if (q.ext_ms == ext_lim - 10'h001)
                begin
                    rst_ev = 1'b1;
                end
            end
        end
        else
        begin
            n.ext_ms = 10'h000;
        end
        // Timer state machine.
        ended = q.ctrl.count_down ? (q.value <= 24'h000001)
                                  : (q.value + 24'h000001 >= q.setpoint);
        if (q.pf_q & ~power_fail_i)
        begin
            if (q.ctrl.pf_policy == PF_IDLE)
            begin
                n.st = ST_DONE;
            end
            else if (q.ctrl.pf_policy == PF_PAUSE)
            begin
                if ((q.st == ST_RUN) | (q.st == ST_DELAY))
                begin
                    n.prev = q.st;
                    n.st   = ST_PAUSE;
                end
            end
        end
        else if (rst_ev)
        begin
            n.st       = ST_RESET;
            n.value    = load_val;
            n.cyc_done = 7'h00;
        end
        else
        begin
            // Continue policy needs no action: state and value persist.
            case (q.st)
                ST_RESET:
                begin
                    n.value    = load_val;
                    n.cyc_done = 7'h00;
                    if (start_ev)
                    begin
                        n.st = ST_RUN;
                    end
                end
                ST_RUN:
                begin
                    if (stop_ev)
                    begin
                        n.prev = ST_RUN;
                        n.st   = ST_PAUSE;
                    end
                    else if (sec)
                    begin
                        if (q.tot_sec == 12'(S_PER_HR - 1))
                        begin
                            n.tot_sec = 12'h000;
                            n.tot_hr  = q.tot_hr + 20'h00001;
                        end
                        else
                        begin
                            n.tot_sec = q.tot_sec + 12'h001;
                        end
                        n.value = q.ctrl.count_down ? q.value - 24'h000001
                                                    : q.value + 24'h000001;
                        if (ended)
                        begin
                            n.cyc_done = q.cyc_done + 7'h01;
                            if (q.ctrl.repeat_en & ((q.cyc_req == 7'h00) |
                                (q.cyc_done + 7'h01 < q.cyc_req)))
                            begin
                                n.st       = ST_DELAY;
                                n.gap_left = q.gap;
                            end
                            else
                            begin
                                n.st = ST_DONE;
                            end
                        end
                    end
                end
                ST_DELAY:
                begin
                    if (stop_ev)
                    begin
                        n.prev = ST_DELAY;
                        n.st   = ST_PAUSE;
                    end
                    else if (sec)
                    begin
                        if (q.gap_left <= 16'h0001)
                        begin
                            n.gap_left = 16'h0000;
                            n.st       = ST_RUN;
                            n.value    = load_val;
                        end
                        else
                        begin
                            n.gap_left = q.gap_left - 16'h0001;
                        end
                    end
                end
                ST_PAUSE:
                begin
                    if (start_ev)
                    begin
                        n.st = q.prev;
                    end
                end
                ST_DONE:
                begin
                    n.st = ST_DONE;
                end
                default:
                begin
                    n.st = ST_RESET;
                end
            endcase
        end
        // Status and control outputs share one behaviour.
        for (int k = 0; k < 3; k++)
        begin
            if ((n.st != q.st) & (n.st == st_of(q.ocfg[k].off_st)))
            begin
                n.orun[k].active  = 1'b0;
                n.orun[k].pending = 1'b0;
            end
            else if ((n.st != q.st) & (n.st == st_of(q.ocfg[k].on_st)))
            begin
                n.orun[k].pending = 1'b1;
                n.orun[k].cnt     = q.ocfg[k].delay;
            end
            else if (q.orun[k].pending)
            begin
                if (q.orun[k].cnt == 16'h0000)
                begin
                    n.orun[k].active  = 1'b1;
                    n.orun[k].pending = 1'b0;
                end
                else if (sec)
                begin
                    n.orun[k].cnt = q.orun[k].cnt - 16'h0001;
                end
            end
            n.outs[k] = q.ocfg[k].enable &
                        (q.orun[k].active ^ q.ocfg[k].invert);
        end
        // Lower readout and phase flag.
        if ((n.st != q.st) & ((n.st == ST_RUN) | (n.st == ST_DELAY)))
        begin
            n.flag_cnt = FLAG_S;
            n.per_cnt  = 4'h0;
        end
        else if (sec)
        begin
            if (q.flag_cnt != 4'h0)
            begin
                n.flag_cnt = q.flag_cnt - 4'h1;
            end
            n.per_cnt = q.per_cnt + 4'h1;
            if ((q.ctrl.readout == RD_PERIODIC) &
                (q.per_cnt + 4'h1 >= FLAG_PERIOD_S))
            begin
                n.per_cnt  = 4'h0;
                n.flag_cnt = FLAG_S;
            end
        end
        if (q.ctrl.readout == RD_OFF)
        begin
            n.lower = 32'h0000_0000;
            n.flag  = 1'b0;
        end
        else if (!q.ctrl.repeat_en)
        begin
            n.lower = {8'h00, fmt_time(q.setpoint, q.ctrl.units)};
            n.flag  = 1'b0;
        end
        else
        begin
            n.flag  = (q.flag_cnt != 4'h0) &
                      ((q.st == ST_RUN) | (q.st == ST_DELAY));
            n.lower = (q.st == ST_DELAY) ?
                      {8'h80, fmt_time({8'h00, q.gap_left}, q.ctrl.units)} :
                      {16'h0000, 1'b0, q.cyc_req, 1'b0, q.cyc_done};
        end
        // Register writes.
        if (wr_i)
        begin
            case (addr_i)
                A_CTRL:     n.ctrl     = cit_ctrl_t'({18'h00000,
                                                     wr_data_i[13:0]});
                A_SETPOINT: n.setpoint = wr_data_i[23:0];
                A_CYCLES:   n.cyc_req  = wr_data_i[6:0];
                A_GAP:      n.gap      = wr_data_i[15:0];
                A_OUT0:     n.ocfg[0]  = cit_out_cfg_t'({8'h00,
                                                        wr_data_i[23:0]});
                A_OUT1:     n.ocfg[1]  = cit_out_cfg_t'({8'h00,
                                                        wr_data_i[23:0]});
                A_OUT2:     n.ocfg[2]  = cit_out_cfg_t'({8'h00,
                                                        wr_data_i[23:0]});
                A_TOTAL_CLR:
                begin
                    if (wr_data_i == CLEAR_KEY)
                    begin
                        n.tot_sec = 12'h000;
                        n.tot_hr  = 20'h00000;
                    end
                end
                default:
                begin
                    n.rdata = 32'h0000_0000;
                end
            endcase
        end
        // Register reads answer in the next cycle.
        if (rd_i)
        begin
            case (addr_i)
                A_CTRL:     n.rdata = q.ctrl;
                A_SETPOINT: n.rdata = {8'h00, q.setpoint};
                A_CYCLES:   n.rdata = {25'h0000000, q.cyc_req};
                A_GAP:      n.rdata = {16'h0000, q.gap};
                A_OUT0:     n.rdata = q.ocfg[0];
                A_OUT1:     n.rdata = q.ocfg[1];
                A_OUT2:     n.rdata = q.ocfg[2];
                A_ELAPSED:  n.rdata = {8'h00,
                                       fmt_time(q.value, q.ctrl.units)};
                A_TOTAL:    n.rdata = {12'h000, q.tot_hr};
                A_STATE:    n.rdata = {4'h0, q.gap_left, q.cyc_done,
                                       q.st};
                A_READOUT:  n.rdata = q.lower;
                default:    n.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            q          <= '0;
            q.ctrl     <= cit_ctrl_t'(CTRL_RST);
            q.st       <= ST_RESET;
            q.prev     <= ST_RUN;
        end
        else
        begin
            q <= n;
        end
    end

    assign rd_data_o       = q.rdata;
    assign status_o        = q.outs[0];
    assign relay_o         = q.outs[2:1];
    assign timer_state_o   = q.st;
    assign lower_readout_o = q.lower;
    assign phase_flag_o    = q.flag;

endmodule

/* File: tb/cit_timer_sva.sv */
// Port checker of the interval timer, bound to its top module.
`timescale 1ns/100ps
module cit_timer_sva
    import cit_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYC
)
(
    // Clock and reset.
    input wire logic       sys_clk_i,
    input wire logic       reset_i,
    // Events.
    input wire logic       wr_i,
    input wire logic       in_a_i,
    input wire logic       btn_start_i,
    input wire logic       btn_timer_rst_i,
    input wire logic       ext_reset_i,
    input wire logic       power_fail_i,
    // State.
    input wire logic [4:0] timer_state_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_start;
        $past(btn_start_i) || $past(in_a_i) != $past(in_a_i, 2);
    endsequence
    sequence s_rst_ev;
        $past(ext_reset_i) || $past(btn_timer_rst_i) || $past(wr_i);
    endsequence
    property p_rst_state;
        $fell(reset_i) |-> timer_state_o == 5'h01;
    endproperty
    property p_onehot;
        $onehot(timer_state_o);
    endproperty
    property p_pf_freeze;
        power_fail_i && $past(power_fail_i) |-> $stable(timer_state_o);
    endproperty
    property p_ext_gate;
        $rose(timer_state_o[0]) |-> $past(ext_reset_i, 6) && $past(ext_reset_i)
            || $past(btn_timer_rst_i) || $past(wr_i);
    endproperty
    property p_done_hold;
        $fell(timer_state_o[4]) |-> s_rst_ev;
    endproperty
    property p_done_entry;
        $rose(timer_state_o[4]) |-> $past(timer_state_o[1])
            || $past(power_fail_i, 2);
    endproperty
    property p_run_start;
        $rose(timer_state_o[1]) && $past(timer_state_o[0]) |-> s_start;
    endproperty
    property p_pause_exit;
        $fell(timer_state_o[3]) |-> s_start or s_rst_ev;
    endproperty
    property p_gap_entry;
        $rose(timer_state_o[2]) |-> $past(timer_state_o[1]) || $past(timer_state_o[3]);
    endproperty
    a_rst_state: assert property (p_rst_state)
        else $error("state not reset after reset");
    a_onehot: assert property (p_onehot)
        else $error("state not one-hot");
    a_pf_freeze: assert property (p_pf_freeze)
        else $error("state moved during power loss");
    a_ext_gate: assert property (p_ext_gate)
        else $error("reset without qualified closure");
    a_done_hold: assert property (p_done_hold)
        else $error("complete left without reset");
    a_done_entry: assert property (p_done_entry)
        else $error("complete entered from wrong state");
    a_run_start: assert property (p_run_start)
        else $error("run without start event");
    a_pause_exit: assert property (p_pause_exit)
        else $error("pause left without event");
    a_gap_entry: assert property (p_gap_entry)
        else $error("restart gap from wrong state");
endmodule
bind cit_timer cit_timer_sva #(.MS_CYCLES(MS_CYCLES)) u_sva
(
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .wr_i(wr_i),
    .in_a_i(in_a_i), .btn_start_i(btn_start_i),
    .btn_timer_rst_i(btn_timer_rst_i), .ext_reset_i(ext_reset_i),
    .power_fail_i(power_fail_i), .timer_state_o(timer_state_o)
);

/* File: tb/cit_field.sv */
// Behavioural model of the sensors, contact, supply and push buttons.
`timescale 1ns/100ps
module cit_field
(
    // Clock.
    input  wire logic sys_clk_i,
    // Levels and events toward the timer.
    output logic      in_a_o,
    output logic      in_b_o,
    output logic      btn_start_o,
    output logic      btn_stop_o,
    output logic      ext_reset_o,
    output logic      power_fail_o
);
    initial
    begin
        {in_a_o, in_b_o, btn_start_o, btn_stop_o, ext_reset_o} = 5'h00;
        power_fail_o = 1'b0;
    end
    task automatic press(input bit stop);
        @(posedge sys_clk_i);
        btn_start_o <= !stop;
        btn_stop_o <= stop;
        @(posedge sys_clk_i);
        btn_start_o <= 1'b0;
        btn_stop_o <= 1'b0;
    endtask
    task automatic set_ab(input bit a, input bit b);
        @(posedge sys_clk_i);
        in_a_o <= a;
        in_b_o <= b;
    endtask
    task automatic hold(input bit pf, input int n);
        @(posedge sys_clk_i);
        if (pf) power_fail_o <= 1'b1;
        else ext_reset_o <= 1'b1;
        repeat (n) @(posedge sys_clk_i);
        power_fail_o <= 1'b0;
        ext_reset_o <= 1'b0;
    endtask
endmodule

/* File: tb/cit_timer_tb.sv */
// Self-checking bench of the interval timer.
`timescale 1ns/100ps
module cit_timer_tb;
    import cit_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        reset_i   = 1'b1;
    logic [7:0]  addr_i    = 8'h00;
    logic [31:0] wr_data_i = 32'h0;
    logic        wr_i = 1'b0, rd_i = 1'b0;
    logic        btn_tr = 1'b0, btn_gr = 1'b0, disp = 1'b1;
    logic [31:0] rd_data_o, lower_readout_o;
    logic        in_a_i, in_b_i, btn_start_i, btn_stop_i, ext_reset_i;
    logic        power_fail_i, status_o, phase_flag_o, lv;
    logic [1:0]  relay_o;
    logic [4:0]  timer_state_o;
    int          err_total = 0, checks_done = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    cit_field field (.sys_clk_i(sys_clk_i), .in_a_o(in_a_i), .in_b_o(in_b_i),
        .btn_start_o(btn_start_i), .btn_stop_o(btn_stop_i),
        .ext_reset_o(ext_reset_i), .power_fail_o(power_fail_i));
    cit_timer #(.MS_CYCLES(4)) uut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
        .rd_data_o(rd_data_o), .in_a_i(in_a_i), .in_b_i(in_b_i),
        .btn_start_i(btn_start_i), .btn_stop_i(btn_stop_i),
        .btn_timer_rst_i(btn_tr), .btn_total_rst_i(btn_gr),
        .display_mode_i(disp), .ext_reset_i(ext_reset_i),
        .power_fail_i(power_fail_i), .status_o(status_o), .relay_o(relay_o),
        .timer_state_o(timer_state_o), .lower_readout_o(lower_readout_o),
        .phase_flag_o(phase_flag_o));
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        @(negedge sys_clk_i);
        check(rd_data_o, exp);
    endtask
    task automatic wait_st(input logic [4:0] exp, input int lim);
        int n = 0;
        while (timer_state_o !== exp && n < lim)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        check({27'h0, timer_state_o}, {27'h0, exp});
        if (n == lim) close_out();
    endtask
    initial
    begin
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        rdc(A_CTRL, CTRL_RST);
        rdc(8'hFC, 32'h0);
        wr(A_CTRL, 32'h0000_054C);
        field.press(1'b0);
        repeat (4) @(negedge sys_clk_i);
        wait_st(ST_RESET, 1);
        $display("test reset and zero setpoint done");
        wr(A_SETPOINT, 32'h0000_0002);
        wr(A_OUT0, 32'h0000_0065);
        wr(A_OUT1, 32'h0000_0067);
        field.press(1'b0);
        wait_st(ST_RUN, 6);
        repeat (3) @(negedge sys_clk_i);
        check(status_o, 1'b1);
        check(relay_o, 2'h0);
        field.press(1'b1);
        wait_st(ST_PAUSE, 6);
        repeat (3) @(negedge sys_clk_i);
        check(status_o, 1'b0);
        check(relay_o, 2'h1);
        field.press(1'b0);
        wait_st(ST_RUN, 6);
        wait_st(ST_DONE, 9000);
        rdc(A_ELAPSED, 32'h0);
        check(lower_readout_o, 32'h0000_0002);
        wr(A_OUT0, 32'h0000_0064);
        field.hold(1'b0, 4);
        repeat (6) @(negedge sys_clk_i);
        check(status_o, 1'b0);
        wait_st(ST_DONE, 1);
        wr(A_OUT0, 32'h0000_0065);
        field.hold(1'b0, 12);
        wait_st(ST_RESET, 20);
        check(status_o, 1'b1);
        $display("test run pause complete done");
        for (int s = 0; s < 4; s++)
        begin
            lv = (s == 0 || s == 2);
            wr(A_CTRL, 32'h0000_0548 | s);
            field.set_ab(!lv, s == 1);
            field.hold(1'b0, 12);
            wait_st(ST_RESET, 20);
            field.set_ab(lv, s == 1);
            wait_st(ST_RUN, 6);
            if (s < 2) field.set_ab(lv, s == 0);
            else field.set_ab(!lv, 1'b0);
            wait_st(ST_PAUSE, 6);
        end
        $display("test start sources done");
        wr(A_CTRL, 32'h0000_055C);
        field.press(1'b0);
        wait_st(ST_RUN, 6);
        field.hold(1'b1, 6);
        wait_st(ST_PAUSE, 6);
        field.press(1'b0);
        wait_st(ST_RUN, 6);
        wr(A_CTRL, 32'h0000_056C);
        field.hold(1'b1, 6);
        repeat (8) @(negedge sys_clk_i);
        wait_st(ST_RUN, 1);
        wr(A_CTRL, 32'h0000_054C);
        field.hold(1'b1, 6);
        wait_st(ST_DONE, 12);
        field.press(1'b0);
        repeat (4) @(negedge sys_clk_i);
        wait_st(ST_DONE, 1);
        btn_tr <= 1'b1;
        wait_st(ST_RESET, 12500);
        $display("test power fail policies done");
        close_out();
    end
endmodule
